/* File: rtl/leiu_pkg.sv */
// Purpose: shared constants and carrier types for the link event interrupt unit
// Assumes: 8-bit registers on a word-per-address configuration port
// Notes: bit positions match in the mask and the flag register
package leiu_pkg;

   localparam int unsigned LEIU_ADDR_W = 12;
   localparam int unsigned LEIU_DATA_W = 8;
   localparam int unsigned LEIU_EVENT_COUNT = 5;

   localparam logic [LEIU_ADDR_W-1:0] LEIU_MASK_OFFSET = 12'h020;
   localparam logic [LEIU_ADDR_W-1:0] LEIU_FLAG_OFFSET = 12'h024;

   localparam logic [LEIU_DATA_W-1:0] LEIU_MASK_RESET = 8'h00;
   localparam logic [LEIU_DATA_W-1:0] LEIU_RDATA_RESET = 8'h00;
   localparam logic LEIU_FLAG_RESET = 1'h0;

   localparam int unsigned LEIU_BIT_INPHASE = 0;
   localparam int unsigned LEIU_BIT_QUADRATURE = 1;
   localparam int unsigned LEIU_BIT_LANE_FIFO = 2;
   localparam int unsigned LEIU_BIT_LINK_READY = 3;
   localparam int unsigned LEIU_BIT_JITTER = 4;
   localparam int unsigned LEIU_RESERVED_LSB = 5;

   // one register access: taken on the clock edge where wr or rd is high
   typedef struct packed {
      logic wr;
      logic rd;
      logic [LEIU_ADDR_W-1:0] addr;
      logic [LEIU_DATA_W-1:0] wdata;
   } leiu_reg_req_s;

   typedef struct packed {
      logic rd_valid;
      logic [LEIU_DATA_W-1:0] rdata;
   } leiu_reg_rsp_s;

   // field order gives the register bit positions 4 down to 0
   typedef struct packed {
      logic jitter_event;
      logic receiver_link_ready;
      logic lane_fifo_error;
      logic quadrature_pattern_error;
      logic inphase_pattern_error;
   } leiu_events_s;

   typedef struct packed {
      logic flag;
   } leiu_cell_s;

endpackage : leiu_pkg

/* File: rtl/leiu_flag_cell.sv */
// Purpose: one sticky event flag with write-one-to-clear
// Assumes: set and clear are synchronous to core_clk
// Notes: a set in the clearing cycle wins
`timescale 1ns/100ps
`default_nettype none
module leiu_flag_cell
   import leiu_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // control
   input wire logic set_event,
   input wire logic clear_req,
   // state
   output logic flag
);

   leiu_cell_s state;
   leiu_cell_s next_state;

   always_comb begin
      next_state = state;
      if (clear_req) begin
         next_state.flag = 1'h0;
      end
      // set after clear so a same-cycle event is not lost
      if (set_event) begin
         next_state.flag = 1'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state.flag <= LEIU_FLAG_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign flag = state.flag;

endmodule : leiu_flag_cell
`default_nettype wire

/* File: rtl/leiu_core.sv */
// Purpose: interrupt mask and sticky event flags for the serial receiver events
// Assumes: event inputs are synchronous to core_clk; one register access per cycle
// Notes: read data returns one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module leiu_core
   import leiu_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // register access
   input wire leiu_reg_req_s reg_req,
   output leiu_reg_rsp_s reg_rsp,
   // detected events
   input wire leiu_events_s events,
   // interrupt and state view
   output logic irq_request,
   output logic [LEIU_EVENT_COUNT-1:0] event_flags
);

   typedef struct packed {
      logic [LEIU_EVENT_COUNT-1:0] mask;
      logic rd_valid;
      logic [LEIU_DATA_W-1:0] rdata;
   } leiu_core_s;

   leiu_core_s state;
   leiu_core_s next_state;
   logic [LEIU_EVENT_COUNT-1:0] set_vec;
   logic [LEIU_EVENT_COUNT-1:0] clear_vec;
   logic [LEIU_EVENT_COUNT-1:0] flags;
   logic flag_write;

   // event sources mapped to flag positions
   always_comb begin
      set_vec = '0;
      set_vec[LEIU_BIT_JITTER] = events.jitter_event;
      set_vec[LEIU_BIT_LINK_READY] = ~events.receiver_link_ready;
      set_vec[LEIU_BIT_LANE_FIFO] = events.lane_fifo_error;
      set_vec[LEIU_BIT_QUADRATURE] = events.quadrature_pattern_error;
      set_vec[LEIU_BIT_INPHASE] = events.inphase_pattern_error;
   end

   assign flag_write = reg_req.wr && (reg_req.addr == LEIU_FLAG_OFFSET);
   // only ones clear; zeros leave flags alone
   assign clear_vec = flag_write ? reg_req.wdata[LEIU_EVENT_COUNT-1:0] : '0;

   generate
      for (genvar i = 0; i < LEIU_EVENT_COUNT; i++) begin : g_flag
         leiu_flag_cell u_cell (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .set_event(set_vec[i]),
            .clear_req(clear_vec[i]),
            .flag(flags[i])
         );
      end
   endgenerate

   always_comb begin
      next_state = state;
      next_state.rd_valid = reg_req.rd;
      if (reg_req.wr && (reg_req.addr == LEIU_MASK_OFFSET)) begin
         // reserved bits dropped on write
         next_state.mask = reg_req.wdata[LEIU_EVENT_COUNT-1:0];
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            LEIU_MASK_OFFSET: begin
               next_state.rdata = {3'h0, state.mask};
            end
            LEIU_FLAG_OFFSET: begin
               next_state.rdata = {3'h0, flags};
            end
            default: begin
               next_state.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state.mask <= LEIU_MASK_RESET[LEIU_EVENT_COUNT-1:0];
         state.rd_valid <= 1'h0;
         state.rdata <= LEIU_RDATA_RESET;
      end else begin
         state <= next_state;
      end
   end

   // from flops only, so no glitch on the request
   assign irq_request = |(flags & state.mask);
   assign event_flags = flags;
   assign reg_rsp.rd_valid = state.rd_valid;
   assign reg_rsp.rdata = state.rdata;

endmodule : leiu_core
`default_nettype wire

/* File: verif/leiu_asserts.sv */
// Purpose: port checks for leiu_core
// Assumes: mask mirrored from writes
// Notes: bound below
`timescale 1ns/100ps
`default_nettype none
module leiu_asserts
   import leiu_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // watched ports
   input wire leiu_reg_req_s reg_req,
   input wire leiu_reg_rsp_s reg_rsp,
   input wire leiu_events_s events,
   input wire logic irq_request,
   input wire logic [LEIU_EVENT_COUNT-1:0] event_flags
);
   logic [4:0] msk;
   wire logic wf = reg_req.wr && reg_req.addr == LEIU_FLAG_OFFSET;
   wire logic [4:0] clr = wf ? reg_req.wdata[4:0] : 5'h00;
   // ready is active high, so its set cause is inverted
   wire logic [4:0] evv = events ^ 5'h08;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) msk <= 5'h00;
      else if (reg_req.wr && reg_req.addr == LEIU_MASK_OFFSET) msk <= reg_req.wdata[4:0];
   end
   a_irq_gate: assert property (irq_request == |(event_flags & msk))
      else $error("irq mismatch");
   a_jit_set: assert property (events.jitter_event |=> event_flags[4])
      else $error("jitter flag");
   a_rdy_set: assert property (!events.receiver_link_ready |=> event_flags[3])
      else $error("ready flag");
   a_evt_set: assert property (|evv[2:0] |=> &(event_flags[2:0] | ~$past(evv[2:0])))
      else $error("event flag");
   a_flag_hold: assert property (##1 (~event_flags & $past(event_flags) & ~$past(clr)) == 5'h00)
      else $error("flag lost");
   a_flag_rise: assert property (##1 (event_flags & ~$past(event_flags) & ~$past(evv)) == 5'h00)
      else $error("flag rose");
   a_rsv_zero: assert property (reg_rsp.rd_valid |-> reg_rsp.rdata[7:5] == 3'h0)
      else $error("reserved bits");
   // read strobe one cycle, data on the following edge
   sequence s_flag_read;
      reg_req.rd && reg_req.addr == LEIU_FLAG_OFFSET;
   endsequence
   sequence s_mask_read;
      reg_req.rd && reg_req.addr == LEIU_MASK_OFFSET;
   endsequence
   a_rd_flags: assert property (s_flag_read |=> reg_rsp.rdata == {3'h0, $past(event_flags)})
      else $error("flag read");
   a_rd_mask: assert property (s_mask_read |=> reg_rsp.rdata == {3'h0, $past(msk)})
      else $error("mask read");
endmodule : leiu_asserts
bind leiu_core leiu_asserts chk_u (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
   .reg_rsp(reg_rsp), .events(events), .irq_request(irq_request), .event_flags(event_flags));
`default_nettype wire

/* File: verif/leiu_core_tb_top.sv */
// Purpose: random bench for leiu_core
// Assumes: one access per cycle
// Notes: model of mask and flags
`timescale 1ns/100ps
`default_nettype none
module leiu_core_tb_top;
   import leiu_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   leiu_reg_req_s reg_req = '0;
   leiu_reg_rsp_s reg_rsp;
   leiu_events_s events = 5'h08;
   logic irq_request;
   logic [4:0] event_flags, nm, nf, clr;
   logic [4:0] m = 5'h00;
   logic [4:0] f = 5'h00;
   logic [7:0] rd = 8'h00;
   logic rv = 1'b0;
   int a;
   int n_errors = 0;
   int checked = 0;
   always #25 core_clk = ~core_clk;
   leiu_core dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rsp(reg_rsp),
      .events(events), .irq_request(irq_request), .event_flags(event_flags));
   function automatic logic [7:0] rd_exp(logic [11:0] ad);
      return ad == LEIU_MASK_OFFSET ? {3'h0, m} : ad == LEIU_FLAG_OFFSET ? {3'h0, f} : 8'h00;
   endfunction : rd_exp
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      void'($urandom(32'hda58ddbf));
      repeat (2) @(posedge core_clk);
      #1 rst_b = 1'b1;
      for (int i = 0; i < 3000; i++) begin
         // mid-run reset: outputs drop at once, mask read back as zero next
         if (i == 1500) begin
            rst_b = 1'b0;
            #1;
            chk({3'h0, event_flags}, 8'h00);
            chk({7'h0, irq_request}, 8'h00);
            chk({7'h0, reg_rsp.rd_valid}, 8'h00);
            chk(reg_rsp.rdata, 8'h00);
            f = 5'h00;
            m = 5'h00;
            rd = 8'h00;
            @(posedge core_clk);
            #1 rst_b = 1'b1;
         end
         // first two cycles: full mask, then clear all flags
         a = i < 2 ? i : (i == 1500 ? 0 : $urandom_range(2));
         reg_req.wr = i < 2 || (i != 1500 && $urandom_range(1));
         reg_req.rd = i == 1500 || $urandom_range(1);
         reg_req.addr = a == 2 ? 12'($urandom) : LEIU_MASK_OFFSET + 12'(a * 4);
         reg_req.wdata = i < 2 ? 8'hFF : 8'($urandom);
         events = 5'($urandom & $urandom & $urandom) ^ 5'h08;
         clr = (reg_req.wr && reg_req.addr == LEIU_FLAG_OFFSET) ? reg_req.wdata[4:0] : 5'h00;
         nf = (f & ~clr) | (events ^ 5'h08);
         nm = (reg_req.wr && reg_req.addr == LEIU_MASK_OFFSET) ? reg_req.wdata[4:0] : m;
         if (reg_req.rd) rd = rd_exp(reg_req.addr);
         rv = reg_req.rd;
         @(posedge core_clk);
         #1;
         f = nf;
         m = nm;
         chk({3'h0, event_flags}, {3'h0, f});
         chk({7'h0, irq_request}, {7'h0, |(f & m)});
         chk({7'h0, reg_rsp.rd_valid}, {7'h0, rv});
         chk(reg_rsp.rdata, rd);
      end
      print_verdict();
   end
endmodule : leiu_core_tb_top
`default_nettype wire
